// ---- test/fsser_master_model.sv ----
/*
 Behavioural network master: explicit requests and I/O assemblies.
 Assumes the block samples its strobes on the rising mclk edge.
*/
`timescale 1ns/10ps

module fsser_master_model (
    input wire mclk,
    output reg expl_req,
    output reg [7:0] req_class,
    output reg [7:0] req_inst,
    output reg [7:0] req_attr,
    output reg [9:0] req_q,
    output reg [7:0] req_vendor_num,
    output reg io_rx,
    output reg io_valid
);
    initial begin
        expl_req = 1'b0;
        io_rx = 1'b0;
        {req_class, req_inst, req_attr, req_q, req_vendor_num} = '0;
        io_valid = 1'b0;
    end

    // Path is always class, instance, attribute
    task send(input [7:0] c, input [7:0] i, input [9:0] q);
        begin
            @(posedge mclk);
            {req_class, req_inst, req_attr} <= {c, i, 8'h01};
            {req_q, req_vendor_num} <= {q, 8'hA7};
            expl_req <= 1'b1;
            @(posedge mclk);
            expl_req <= 1'b0;
            // Stale class, instance and flag fields are scrambled; attribute and vendor number are held
            {req_class, req_inst, req_q} <= ~{c, i, q};
        end
    endtask

    task io(input ok);
        begin
            @(posedge mclk);
            io_valid <= ok;
            io_rx <= 1'b1;
            @(posedge mclk);
            io_rx <= 1'b0;
            io_valid <= ~ok;
        end
    endtask
endmodule // fsser_master_model

// ---- test/fsser_status_monitor.sv ----
/*
 Port checker for the status block.
 Assumes one clock and a synchronous active high reset.
*/
`timescale 1ns/10ps

module fsser_status_monitor (
    input wire mclk,
    input wire rst,
    input wire async_err,
    input wire async_fault,
    input wire expl_req,
    input wire [7:0] req_inst,
    input wire io_rx,
    input wire io_valid,
    input wire expl_resp_r,
    input wire [7:0] gen_code_r,
    input wire [7:0] add_code_r,
    input wire mod_green_r,
    input wire mod_red_r,
    input wire [15:0] drive_status_word_r,
    input wire [15:0] mode_function_status_word_r,
    input wire [3:0] op_state_r,
    input wire err_response_r
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    a_resp_next: assert property (expl_req |=> expl_resp_r)
        else $error("no response after request");
    a_unknown_path: assert property (expl_req && req_inst == 8'h00
        |=> gen_code_r == 8'h05) else $error("instance 0 not 05");
    a_add_zero: assert property (expl_resp_r && gen_code_r != 8'h1F
        |-> add_code_r == 8'h00) else $error("stray additional code");
    a_async_state: assert property (async_err
        |=> op_state_r == ($past(async_fault) ? 4'h9 : 4'h7))
        else $error("wrong state after async error");
    a_error_flag: assert property (async_err
        |=> drive_status_word_r[6] && err_response_r)
        else $error("async error flag missing");
    a_msg_err_set: assert property (io_rx && !io_valid
        |=> mode_function_status_word_r[6]) else $error("flag not set");
    a_msg_err_clear: assert property (io_rx && io_valid
        |=> !mode_function_status_word_r[6]) else $error("flag not clear");
    // Bicolour start-up alternates, so both lit is never right
    a_mod_single: assert property (!(mod_green_r && mod_red_r))
        else $error("module LED both colours");
endmodule // fsser_status_monitor

bind fsser_status fsser_status_monitor u_mon (
    .mclk, .rst, .async_err, .async_fault, .expl_req, .req_inst, .io_rx,
    .io_valid, .expl_resp_r, .gen_code_r, .add_code_r, .mod_green_r,
    .mod_red_r, .drive_status_word_r, .mode_function_status_word_r,
    .op_state_r, .err_response_r
);

// ---- test/tb.sv ----
/*
 Self-checking bench for the status block with a master model.
 Assumes 25 MHz mclk and a shortened blink half period.
*/
`timescale 1ns/10ps

module tb;
    localparam HALF = 4;
    localparam [15:0] ID_VAL = 16'h3C96; // Arbitrary identity value
    localparam [29:0] MOD_EXP = {5'h0C, 5'h0F, 5'h12, 5'h1B, 5'h1E, 5'h0B};
    localparam [29:0] NET_EXP = {5'h0C, 5'h0F, 5'h1B, 5'h12, 5'h1E, 5'h0B};
    localparam [33:0] EX [0:11] = '{
        {8'hFF, 10'h1F8, 16'h0500}, {8'h01, 10'h1F8, 16'h0500},
        {8'h02, 10'h1B8, 16'h1400}, {8'h04, 10'h2F8, 16'h0E00},
        {8'h06, 10'h178, 16'h0F00}, {8'hF4, 10'h1D8, 16'h1000},
        {8'hF5, 10'h1E8, 16'h0C00}, {8'hF6, 10'h1FC, 16'h1300},
        {8'h64, 10'h1FA, 16'h1500}, {8'h01, 10'h1F0, 16'h0900},
        {8'h02, 10'h1F9, 16'h1FA7}, {8'h04, 10'h1F8, 16'h0000}};
    reg mclk = 1'b0;
    reg rst = 1'b1;
    reg [3:0] addr = 4'h0;
    reg [15:0] wdata = 16'h0000;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg [1:0] link_up = 2'h0;
    reg [1:0] link_100 = 2'h0;
    reg [1:0] traffic = 2'h0;
    reg async_err = 1'b0;
    reg async_fault = 1'b0;
    reg [15:0] async_err_num = 16'h0000;
    reg [4:0] seen_m, seen_n;
    reg [3:0] seen_a;
    wire expl_req, io_rx, io_valid, expl_resp_r, mod_green_r, mod_red_r;
    wire net_green_r, net_red_r, err_response_r, irq_r;
    wire [7:0] req_class, req_inst, req_attr, req_vendor_num;
    wire [7:0] gen_code_r, add_code_r;
    wire [9:0] req_q;
    wire [1:0] act_green_r, act_yellow_r;
    wire [3:0] op_state_r;
    wire [15:0] rdata_r, drive_status_word_r, mode_function_status_word_r;
    integer errors = 0;
    integer checks_done = 0;
    integer i;

    always #20 mclk = ~mclk;

    fsser_master_model mst (.mclk, .expl_req, .req_class, .req_inst,
        .req_attr, .req_q, .req_vendor_num, .io_rx, .io_valid);

    fsser_status #(.HALF_CYC(HALF), .IDENT(ID_VAL)) dut (
        .mclk, .rst, .addr, .wdata, .wr, .rd, .rdata_r, .link_up,
        .link_100, .traffic, .async_err, .async_fault, .async_err_num,
        .expl_req, .req_class, .req_inst, .req_attr,
        .req_write(req_q[9]), .req_settable(req_q[8]),
        .req_priv_ok(req_q[7]), .req_attr_ok(req_q[6]),
        .req_mode_ok(req_q[5]), .req_obj_ok(req_q[4]),
        .req_value_ok(req_q[3]), .req_short(req_q[2]),
        .req_long(req_q[1]), .req_vendor_err(req_q[0]), .req_vendor_num,
        .io_rx, .io_valid, .expl_resp_r, .gen_code_r, .add_code_r,
        .act_green_r, .act_yellow_r, .mod_green_r, .mod_red_r,
        .net_green_r, .net_red_r, .drive_status_word_r,
        .mode_function_status_word_r, .op_state_r, .err_response_r, .irq_r);

    task check(input [15:0] s, input [15:0] e);
        begin
            checks_done = checks_done + 1;
            if (s !== e) begin
                errors = errors + 1;
                $display("mismatch at %0t: seen %h expected %h", $time, s, e);
            end
        end
    endtask

    task wr_reg(input [3:0] a, input [15:0] d);
        begin
            @(posedge mclk);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge mclk);
            wr <= 1'b0;
        end
    endtask

    // Read data live for one cycle only, so sample just after the edge
    task rd_reg(input [3:0] a, input [15:0] e);
        begin
            @(posedge mclk);
            addr <= a;
            rd <= 1'b1;
            @(posedge mclk);
            rd <= 1'b0;
            #1 check(rdata_r, e);
        end
    endtask

    task async_ev(input f, input [15:0] n, input [3:0] st);
        begin
            @(posedge mclk);
            async_err <= 1'b1;
            async_fault <= f;
            async_err_num <= n;
            @(posedge mclk);
            async_err <= 1'b0;
            #1 check({drive_status_word_r[6], err_response_r, op_state_r},
                {2'b11, st});
            rd_reg(4'h4, n);
        end
    endtask

    // Two half periods seen, so both levels of every flash show up
    task scan;
        begin
            seen_m = 5'h00;
            seen_n = 5'h00;
            seen_a = 4'h0;
            repeat (2 * HALF) begin
                @(posedge mclk);
                #1;
                seen_m = seen_m | {mod_green_r, !mod_green_r, mod_red_r,
                    !mod_red_r, mod_green_r == mod_red_r};
                seen_n = seen_n | {net_green_r, !net_green_r, net_red_r,
                    !net_red_r, net_green_r == net_red_r};
                seen_a = seen_a | {act_green_r[0], !act_green_r[0],
                    act_yellow_r[1], !act_yellow_r[1]};
            end
        end
    endtask

    task complete_run;
        begin
            $display("checks %0d, mismatches %0d", checks_done, errors);
            if (errors == 0 && checks_done > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask

    initial begin
        repeat (3000) @(posedge mclk);
        errors = errors + 1;
        complete_run;
    end

    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        rd_reg(4'h9, ID_VAL);
        rd_reg(4'h0, 16'h0001);
        rd_reg(4'hF, 16'h0000);
        wr_reg(4'h3, 16'hFFFF);
        rd_reg(4'h3, 16'h0000);
        $display("test registers done");
        for (i = 0; i < 12; i = i + 1) begin
            mst.send(EX[i][33:26], (i == 1) ? 8'h00 : 8'h01,
                EX[i][25:16]);
            #1 check({gen_code_r, add_code_r}, EX[i][15:0]);
            check({15'h0000, expl_resp_r}, 16'h0001);
            if (i == 10)
                rd_reg(4'h6, 16'h1FA7);
        end
        $display("test explicit done");
        mst.io(1'b0);
        #1 check(mode_function_status_word_r & 16'h0040, 16'h0040);
        rd_reg(4'h6, 16'h1000);
        mst.io(1'b1);
        #1 check(mode_function_status_word_r & 16'h0040, 16'h0000);
        $display("test io done");
        wr_reg(4'h8, 16'h0000);
        async_ev(1'b0, 16'h0123, 4'h7);
        rd_reg(4'h7, 16'h0007);
        check({15'h0000, irq_r}, 16'h0000);
        wr_reg(4'h8, 16'h0001);
        repeat (2) @(posedge mclk);
        #1 check({15'h0000, irq_r}, 16'h0001);
        wr_reg(4'h7, 16'h0001);
        repeat (2) @(posedge mclk);
        #1 check({15'h0000, irq_r}, 16'h0000);
        rd_reg(4'h7, 16'h0006);
        wr_reg(4'h2, 16'h0040);
        #1 check({15'h0000, drive_status_word_r[6]}, 16'h0000);
        async_ev(1'b1, 16'h0456, 4'h9);
        $display("test async done");
        @(posedge mclk);
        link_up <= 2'b11;
        link_100 <= 2'b01;
        repeat (5) @(posedge mclk);
        #1 check({12'h000, act_green_r, act_yellow_r}, 16'h0006);
        @(posedge mclk);
        link_up <= 2'b00;
        repeat (5) @(posedge mclk);
        #1 check({12'h000, act_green_r, act_yellow_r}, 16'h0000);
        @(posedge mclk);
        link_up <= 2'b11;
        traffic <= 2'b11;
        for (i = 0; i < 6; i = i + 1) begin
            wr_reg(4'h0, i[15:0]);
            wr_reg(4'h1, i[15:0]);
            repeat (4) @(posedge mclk);
            scan;
            check({11'h000, seen_m}, {11'h000, MOD_EXP[i*5 +: 5]});
            check({11'h000, seen_n}, {11'h000, NET_EXP[i*5 +: 5]});
            check({12'h000, seen_a}, 16'h000F);
        end
        $display("test leds done");
        complete_run;
    end
endmodule // tb

// ---- verilog/fsser_blink.v ----
/*
 Common blink timer for every LED pattern.
 Assumes one free running clock and a synchronous reset.
*/
`timescale 1ns/10ps
`include "fsser_defines.vh"

module fsser_blink #(
    parameter HALF_CYC = `FSSER_BLINK_HALF_CYC
) (
    input wire mclk,
    input wire rst,
    output reg phase_r
);
    reg [23:0] cnt_r;

    always @(posedge mclk) begin
        if (rst) begin
            cnt_r <= 24'h000000;
            phase_r <= 1'b0;
        end else if (cnt_r == HALF_CYC - 1) begin
            cnt_r <= 24'h000000;
            phase_r <= ~phase_r; // [R19]
        end else begin
            cnt_r <= cnt_r + 24'h000001;
        end
    end
endmodule // fsser_blink

// ---- verilog/fsser_defines.vh ----
/*
 Constants for the fieldbus status and error report block: register
 offsets, field positions, error codes, LED modes and timing counts.
 Assumes a 25 MHz mclk.
*/
// Function
// [R1] Activity LED: off, green 100M, yellow 10M
// [R2] Traffic flashes activity LED in speed colour
// [R3] Module LED patterns per module state
// [R4] Network LED patterns per network state
// [R5] Async error starts response, state 7/9
// [R6] Async error sets status word bit 6
// [R7] Async error stores number in last error
// [R8] Explicit error response: general then additional
// [R9] Code 1F carries vendor error number
// [R10] Pending error code readable at 100.1.1
// [R11] Bad I/O command sets flag bit 6
// [R12] Next valid output assembly clears flag
// [R13] Codes 00, 05, 09, 0C
// [R14] Unknown path stops, reports 05
// [R15] Codes 0E, 0F, 10
// [R16] Codes 13, 14, 15
// [R17] Address is class, instance, attribute
// [R18] Classes 1,2,4,6,244,245,246 supported
// [R19] One blink timer, colours alternate per half
`ifndef FSSER_DEFINES_VH
`define FSSER_DEFINES_VH

`define FSSER_CLK_HZ 25000000
`define FSSER_BLINK_HALF_MS 250
`define FSSER_BLINK_HALF_CYC (`FSSER_CLK_HZ / 1000 * `FSSER_BLINK_HALF_MS)

`define FSSER_ADDR_CTRL 4'h0
`define FSSER_ADDR_NET 4'h1
`define FSSER_ADDR_DRIVE_STAT 4'h2
`define FSSER_ADDR_MF_STAT 4'h3
`define FSSER_ADDR_LAST_ERR 4'h4
`define FSSER_ADDR_ERR_RESP 4'h5
`define FSSER_ADDR_PEND_ERR 4'h6
`define FSSER_ADDR_IRQ_STAT 4'h7
`define FSSER_ADDR_IRQ_MASK 4'h8
`define FSSER_ADDR_IDENT 4'h9

`define FSSER_ERROR_BIT 6
`define FSSER_MSG_ERR_BIT 6

`define FSSER_GEC_SUCCESS 8'h00
`define FSSER_GEC_PATH_UNKNOWN 8'h05
`define FSSER_GEC_BAD_VALUE 8'h09
`define FSSER_GEC_OBJ_STATE 8'h0C
`define FSSER_GEC_NOT_SETTABLE 8'h0E
`define FSSER_GEC_PRIVILEGE 8'h0F
`define FSSER_GEC_DEV_STATE 8'h10
`define FSSER_GEC_TOO_LITTLE 8'h13
`define FSSER_GEC_NO_ATTR 8'h14
`define FSSER_GEC_TOO_MUCH 8'h15
`define FSSER_GEC_VENDOR 8'h1F

`define FSSER_OPST_QUICK_STOP 4'h7
`define FSSER_OPST_FAULT 4'h9

`define FSSER_ERRTAB_CLASS 8'h64
`define FSSER_ERRTAB_INST 8'h01
`define FSSER_ERRTAB_ATTR 8'h01

`define FSSER_MOD_OFF 3'h0
`define FSSER_MOD_START 3'h1
`define FSSER_MOD_IDLE 3'h2
`define FSSER_MOD_READY 3'h3
`define FSSER_MOD_RECOV 3'h4
`define FSSER_MOD_FATAL 3'h5

`define FSSER_NET_NOIP 3'h0
`define FSSER_NET_START 3'h1
`define FSSER_NET_CONN 3'h2
`define FSSER_NET_UNCONN 3'h3
`define FSSER_NET_TIMEOUT 3'h4
`define FSSER_NET_IPCONF 3'h5

`define FSSER_IRQ_ASYNC 0
`define FSSER_IRQ_EXPL 1
`define FSSER_IRQ_IO 2

`endif

// ---- verilog/fsser_status.v ----
/*
 Status LED driver and error reporting for the fieldbus module.
 Assumes link pins are asynchronous and enter through two flops; the
 request decoder pulses arrive on mclk; registers via plain port.
*/
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "fsser_defines.vh"

module fsser_status #(
    parameter HALF_CYC = `FSSER_BLINK_HALF_CYC,
    parameter [15:0] IDENT = 16'h5A5A // Arbitrary, not a maker's code
) (
    input wire mclk,
    input wire rst,
    input wire [3:0] addr,
    input wire [15:0] wdata,
    input wire wr,
    input wire rd,
    output reg [15:0] rdata_r,
    input wire [1:0] link_up,
    input wire [1:0] link_100,
    input wire [1:0] traffic,
    input wire async_err,
    input wire async_fault,
    input wire [15:0] async_err_num,
    input wire expl_req,
    input wire [7:0] req_class,
    input wire [7:0] req_inst,
    input wire [7:0] req_attr,
    input wire req_write,
    input wire req_settable,
    input wire req_priv_ok,
    input wire req_attr_ok,
    input wire req_mode_ok,
    input wire req_obj_ok,
    input wire req_value_ok,
    input wire req_short,
    input wire req_long,
    input wire req_vendor_err,
    input wire [7:0] req_vendor_num,
    input wire io_rx,
    input wire io_valid,
    output reg expl_resp_r,
    output reg [7:0] gen_code_r,
    output reg [7:0] add_code_r,
    output reg [1:0] act_green_r,
    output reg [1:0] act_yellow_r,
    output reg mod_green_r,
    output reg mod_red_r,
    output reg net_green_r,
    output reg net_red_r,
    output reg [15:0] drive_status_word_r,
    output reg [15:0] mode_function_status_word_r,
    output reg [3:0] op_state_r,
    output reg err_response_r,
    output reg irq_r
);
    reg [1:0] up_s1_r;
    reg [1:0] up_s2_r;
    reg [1:0] spd_s1_r;
    reg [1:0] spd_s2_r;
    reg [1:0] trf_s1_r;
    reg [1:0] trf_s2_r;
    reg [2:0] mod_mode_r;
    reg [2:0] net_mode_r;
    reg [15:0] last_error_number_r;
    reg [15:0] pend_err_r;
    reg [2:0] irq_stat_r;
    reg [2:0] irq_mask_r;
    reg [2:0] irq_set;
    reg [7:0] gec_nxt;
    reg [7:0] add_nxt;
    wire phase;
    wire mod_wr;
    wire net_wr;
    wire stat_wr;
    wire mask_wr;
    wire drv_clr;
    wire io_bad;
    wire io_good;
    wire [2:0] irq_clr;
    genvar gi;

    // Shared blink phase keeps all LEDs in step
    fsser_blink #(
        .HALF_CYC(HALF_CYC)
    ) u_blink (
        .mclk(mclk),
        .rst(rst),
        .phase_r(phase)
    );

    // Class table; unknown classes end path processing
    function known_class;
        input [7:0] c;
        begin
            case (c)
                8'h01, 8'h02, 8'h04, 8'h06: known_class = 1'b1;
                8'hF4, 8'hF5, 8'hF6: known_class = 1'b1; // [R18]
                `FSSER_ERRTAB_CLASS: known_class = 1'b1;
                default: known_class = 1'b0;
            endcase
        end
    endfunction

    // Drive one bicolour LED from a mode and the blink phase
    function [1:0] led_pat;
        input [2:0] mode;
        input ph;
        input is_net;
        begin
            if (!is_net) begin
                case (mode)
                    `FSSER_MOD_OFF: led_pat = 2'b00;
                    `FSSER_MOD_START: led_pat = {~ph, ph}; // [R19]
                    `FSSER_MOD_IDLE: led_pat = {ph, 1'b0};
                    `FSSER_MOD_READY: led_pat = 2'b10;
                    `FSSER_MOD_RECOV: led_pat = {1'b0, ph};
                    `FSSER_MOD_FATAL: led_pat = 2'b01;
                    default: led_pat = 2'b00;
                endcase // [R3]
            end else begin
                case (mode)
                    `FSSER_NET_NOIP: led_pat = 2'b00;
                    `FSSER_NET_START: led_pat = {~ph, ph};
                    `FSSER_NET_CONN: led_pat = 2'b10;
                    `FSSER_NET_UNCONN: led_pat = {ph, 1'b0};
                    `FSSER_NET_TIMEOUT: led_pat = {1'b0, ph};
                    `FSSER_NET_IPCONF: led_pat = 2'b01;
                    default: led_pat = 2'b00;
                endcase // [R4]
            end
        end
    endfunction

    // One decode for every register write strobe
    function hit;
        input [3:0] a;
        input [3:0] sel;
        input strobe;
        begin
            hit = strobe && (a == sel);
        end
    endfunction

    assign mod_wr = hit(addr, `FSSER_ADDR_CTRL, wr);
    assign net_wr = hit(addr, `FSSER_ADDR_NET, wr);
    assign stat_wr = hit(addr, `FSSER_ADDR_IRQ_STAT, wr);
    assign mask_wr = hit(addr, `FSSER_ADDR_IRQ_MASK, wr);
    // Only a one in the error bit clears it
    assign drv_clr = hit(addr, `FSSER_ADDR_DRIVE_STAT, wr) &&
        wdata[`FSSER_ERROR_BIT];
    assign io_bad = io_rx && !io_valid;
    assign io_good = io_rx && io_valid;
    // Write one to clear; a new event still wins
    assign irq_clr = stat_wr ? wdata[2:0] : 3'b000;

    // Link pins are asynchronous, two flops first
    always @(posedge mclk) begin
        if (rst) begin
            up_s1_r <= 2'b00;
            up_s2_r <= 2'b00;
            spd_s1_r <= 2'b00;
            spd_s2_r <= 2'b00;
            trf_s1_r <= 2'b00;
            trf_s2_r <= 2'b00;
        end else begin
            up_s1_r <= link_up;
            up_s2_r <= up_s1_r;
            spd_s1_r <= link_100;
            spd_s2_r <= spd_s1_r;
            trf_s1_r <= traffic;
            trf_s2_r <= trf_s1_r;
        end
    end

    // Flash gates the steady colour with the blink phase
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_act
            always @(posedge mclk) begin
                if (rst) begin
                    act_green_r[gi] <= 1'b0;
                    act_yellow_r[gi] <= 1'b0;
                end else begin
                    act_green_r[gi] <= up_s2_r[gi] && spd_s2_r[gi] &&
                        (!trf_s2_r[gi] || phase); // [R1] [R2]
                    act_yellow_r[gi] <= up_s2_r[gi] && !spd_s2_r[gi] &&
                        (!trf_s2_r[gi] || phase); // [R1] [R2]
                end
            end
        end
    endgenerate

    // Patterns registered so the pins never glitch
    always @(posedge mclk) begin
        if (rst) begin
            mod_mode_r <= `FSSER_MOD_START;
            net_mode_r <= `FSSER_NET_START;
            {mod_green_r, mod_red_r} <= 2'b00;
            {net_green_r, net_red_r} <= 2'b00;
        end else begin
            if (mod_wr)
                mod_mode_r <= wdata[2:0];
            if (net_wr)
                net_mode_r <= wdata[2:0];
            {mod_green_r, mod_red_r} <= led_pat(mod_mode_r, phase, 1'b0);
            {net_green_r, net_red_r} <= led_pat(net_mode_r, phase, 1'b1);
        end
    end

    // Explicit request decode, first failing check wins
    always @* begin
        add_nxt = 8'h00;
        if (!known_class(req_class) || req_inst == 8'h00)
            gec_nxt = `FSSER_GEC_PATH_UNKNOWN; // [R14] [R17]
        else if (!req_attr_ok)
            gec_nxt = `FSSER_GEC_NO_ATTR; // [R16]
        else if (req_write && !req_settable)
            gec_nxt = `FSSER_GEC_NOT_SETTABLE; // [R15]
        else if (!req_priv_ok)
            gec_nxt = `FSSER_GEC_PRIVILEGE; // [R15]
        else if (!req_mode_ok)
            gec_nxt = `FSSER_GEC_DEV_STATE; // [R15]
        else if (!req_obj_ok)
            gec_nxt = `FSSER_GEC_OBJ_STATE; // [R13]
        else if (req_short)
            gec_nxt = `FSSER_GEC_TOO_LITTLE; // [R16]
        else if (req_long)
            gec_nxt = `FSSER_GEC_TOO_MUCH; // [R16]
        else if (!req_value_ok)
            gec_nxt = `FSSER_GEC_BAD_VALUE; // [R13]
        else if (req_vendor_err) begin
            gec_nxt = `FSSER_GEC_VENDOR;
            add_nxt = req_vendor_num; // [R9]
        end else
            gec_nxt = `FSSER_GEC_SUCCESS; // [R13]
    end

    // Codes hold until the next request
    always @(posedge mclk) begin
        if (rst) begin
            expl_resp_r <= 1'b0;
            gen_code_r <= 8'h00;
            add_code_r <= 8'h00;
            pend_err_r <= 16'h0000;
        end else begin
            expl_resp_r <= expl_req;
            if (expl_req) begin
                gen_code_r <= gec_nxt; // [R8]
                add_code_r <= add_nxt; // [R8]
                if (gec_nxt != `FSSER_GEC_SUCCESS)
                    pend_err_r <= {gec_nxt, add_nxt}; // [R10]
            end else if (io_bad) begin
                pend_err_r <= {`FSSER_GEC_DEV_STATE, 8'h00}; // [R10]
            end
        end
    end

    // Async error holds its state until software clears it
    always @(posedge mclk) begin
        if (rst) begin
            drive_status_word_r <= 16'h0000;
            op_state_r <= 4'h0;
            err_response_r <= 1'b0;
            last_error_number_r <= 16'h0000;
        end else if (async_err) begin
            drive_status_word_r[`FSSER_ERROR_BIT] <= 1'b1; // [R6]
            err_response_r <= 1'b1; // [R5]
            op_state_r <= async_fault ? `FSSER_OPST_FAULT :
                `FSSER_OPST_QUICK_STOP; // [R5]
            last_error_number_r <= async_err_num; // [R7]
        end else if (drv_clr) begin
            drive_status_word_r[`FSSER_ERROR_BIT] <= 1'b0;
            err_response_r <= 1'b0;
            op_state_r <= 4'h0;
        end
    end

    // Set wins over clear when both land in one cycle
    always @(posedge mclk) begin
        if (rst)
            mode_function_status_word_r <= 16'h0000;
        else if (io_bad)
            mode_function_status_word_r[`FSSER_MSG_ERR_BIT] <= 1'b1; // [R11]
        else if (io_good)
            mode_function_status_word_r[`FSSER_MSG_ERR_BIT] <= 1'b0; // [R12]
    end

    // Async errors, bad requests and bad assemblies raise events
    always @* begin
        irq_set = 3'b000;
        irq_set[`FSSER_IRQ_ASYNC] = async_err;
        irq_set[`FSSER_IRQ_EXPL] = expl_req &&
            (gec_nxt != `FSSER_GEC_SUCCESS);
        irq_set[`FSSER_IRQ_IO] = io_bad;
    end

    // Sticky bits, one per event; a set beats a clear
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_irq
            always @(posedge mclk) begin
                if (rst)
                    irq_stat_r[gi] <= 1'b0;
                else if (irq_set[gi])
                    irq_stat_r[gi] <= 1'b1;
                else if (irq_clr[gi])
                    irq_stat_r[gi] <= 1'b0;
            end
        end
    endgenerate

    always @(posedge mclk) begin
        if (rst) begin
            irq_mask_r <= 3'b000;
            irq_r <= 1'b0;
        end else begin
            if (mask_wr)
                irq_mask_r <= wdata[2:0];
            irq_r <= |(irq_stat_r & irq_mask_r);
        end
    end

    // Read data stands one cycle, zero otherwise
    always @(posedge mclk) begin
        if (rst)
            rdata_r <= 16'h0000;
        else if (rd) begin
            case (addr)
                `FSSER_ADDR_CTRL: rdata_r <= {13'h0000, mod_mode_r};
                `FSSER_ADDR_NET: rdata_r <= {13'h0000, net_mode_r};
                `FSSER_ADDR_DRIVE_STAT: rdata_r <= drive_status_word_r;
                `FSSER_ADDR_MF_STAT: rdata_r <= mode_function_status_word_r;
                `FSSER_ADDR_LAST_ERR: rdata_r <= last_error_number_r;
                `FSSER_ADDR_ERR_RESP: rdata_r <= {gen_code_r, add_code_r};
                `FSSER_ADDR_PEND_ERR: rdata_r <= pend_err_r; // [R10]
                `FSSER_ADDR_IRQ_STAT: rdata_r <= {13'h0000, irq_stat_r};
                `FSSER_ADDR_IRQ_MASK: rdata_r <= {13'h0000, irq_mask_r};
                `FSSER_ADDR_IDENT: rdata_r <= IDENT;
                default: rdata_r <= 16'h0000;
            endcase
        end else
            rdata_r <= 16'h0000;
    end
endmodule // fsser_status
